// ---- rtl/cfb_device.sv ----
// module: fan-out buffer with serial enable configuration slave
`timescale 1ns/1ps
`default_nettype none
module cfb_device
  import cfb_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   rstn_i,
  cfb_link_if.slave                   link,
  input  wire logic                   reference_clock_in_i,
  input  wire logic                   tristate_control_i,
  output logic [CFB_NUM_OUT-1:0]      buffered_clock_out_o,
  output logic [CFB_NUM_OUT-1:0]      buffered_clock_oe_o,
  output logic [CFB_NUM_OUT-1:0]      enable_state_o
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0]             scl_s;
    logic [2:0]             sda_s;
    logic [2:0]             rclk_s;
    logic [2:0]             tri_s;
    logic                   scl_v;
    logic                   sda_v;
    logic                   rclk_v;
    logic                   tri_v;
    cfb_dev_st_t            st;
    logic [3:0]             bitc;
    logic [7:0]             shift;
    logic [2:0]             bytec;
    logic                   addr_phase;
    logic                   sda_oe;
    logic [CFB_NUM_OUT-1:0] en;
    logic [CFB_NUM_OUT-1:0] out;
    logic [CFB_NUM_OUT-1:0] oe;
  } cfb_dev_t;

  cfb_dev_t s_r;
  cfb_dev_t s_nxt;

  // filtered level: changes once the last two stages agree
  function automatic logic filt(input logic [2:0] s, input logic prev);
    filt = (s[2] == s[1]) ? s[1] : prev;
  endfunction : filt

  ////////////////////////////////////////////////////////////////////////////
  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic rclk_f;
  logic tri_f;

  always_comb begin
    s_nxt = s_r;
    s_nxt.scl_s  = {s_r.scl_s[1:0], link.scl};
    s_nxt.sda_s  = {s_r.sda_s[1:0], link.sda};
    s_nxt.rclk_s = {s_r.rclk_s[1:0], reference_clock_in_i};
    s_nxt.tri_s  = {s_r.tri_s[1:0], tristate_control_i};
    scl_f  = filt(s_r.scl_s, s_r.scl_v);
    sda_f  = filt(s_r.sda_s, s_r.sda_v);
    // reference and tristate pins use the same filter as the link, so a runt pulse is not passed on
    rclk_f = filt(s_r.rclk_s, s_r.rclk_v);
    tri_f  = filt(s_r.tri_s, s_r.tri_v);
    s_nxt.scl_v  = scl_f;
    s_nxt.sda_v  = sda_f;
    s_nxt.rclk_v = rclk_f;
    s_nxt.tri_v  = tri_f;
    scl_rise = scl_f & ~s_r.scl_v;
    scl_fall = ~scl_f & s_r.scl_v;
    start_c  = s_r.scl_v & scl_f & s_r.sda_v & ~sda_f; // R9
    stop_c   = s_r.scl_v & scl_f & ~s_r.sda_v & sda_f; // R10
    if (stop_c) begin
      s_nxt.st     = CFB_D_IDLE; // R10
      s_nxt.sda_oe = 1'b0;
    end else if (start_c) begin
      s_nxt.st         = CFB_D_RECV; // R9
      s_nxt.bitc       = 4'h0;
      s_nxt.bytec      = 3'h0;
      s_nxt.addr_phase = 1'b1;
      s_nxt.sda_oe     = 1'b0;
    end else begin
      case (s_r.st)
        CFB_D_RECV: begin
          // data sampled on clock rise only, so it may move while low
          if (scl_rise) begin // R8
            s_nxt.shift = {s_r.shift[6:0], sda_f}; // R7
            s_nxt.bitc  = s_r.bitc + 4'h1;
          end else if (scl_fall && s_r.bitc == 4'h8) begin
            s_nxt.bitc = 4'h0;
            if (s_r.addr_phase) begin
              if (s_r.shift == {CFB_SLAVE_ADDR, 1'b0}) begin // R5 R15
                s_nxt.st     = CFB_D_ACK;
                s_nxt.sda_oe = 1'b1; // R6
              end else begin
                s_nxt.st = CFB_D_IGNORE;
              end
            end else begin
              s_nxt.st     = CFB_D_ACK; // R12 R13
              s_nxt.sda_oe = 1'b1; // R7
              case (s_r.bytec)
                3'(CFB_BYTE_LOW): s_nxt.en[CFB_LOW_POS +: 8] = s_r.shift; // R16 R14
                3'(CFB_BYTE_MID): s_nxt.en[CFB_MID_POS +: 8] = s_r.shift; // R17 R14
                3'(CFB_BYTE_HIGH): s_nxt.en[CFB_HIGH_POS +: 2] = s_r.shift[CFB_HIGH_BITPOS +: 2]; // R18
                default: ;
              endcase
              if (s_r.bytec != 3'(CFB_BYTE_HIGH + 1)) begin
                s_nxt.bytec = s_r.bytec + 3'h1;
              end
            end
          end
        end
        CFB_D_ACK: begin
          if (scl_rise) begin
            s_nxt.st = CFB_D_ACKEND;
          end
        end
        CFB_D_ACKEND: begin
          if (scl_fall) begin
            s_nxt.sda_oe     = 1'b0;
            s_nxt.addr_phase = 1'b0;
            s_nxt.st         = CFB_D_RECV;
          end
        end
        default: ;
      endcase
    end
    for (int i = 0; i < CFB_NUM_OUT; i++) begin
      s_nxt.oe[i]  = tri_f; // R2 R19
      s_nxt.out[i] = tri_f & s_r.en[i] & rclk_f; // R3 R4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r       <= '0;
      s_r.scl_s <= 3'h7;
      s_r.sda_s <= 3'h7;
      s_r.scl_v <= 1'b1;
      s_r.sda_v <= 1'b1;
      s_r.st    <= CFB_D_IDLE;
      s_r.en    <= CFB_EN_RESET; // R1
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.sda_s_o          = 1'b0;
  assign link.sda_s_oe         = s_r.sda_oe;
  assign buffered_clock_out_o  = s_r.out;
  assign buffered_clock_oe_o   = s_r.oe;
  assign enable_state_o        = s_r.en;
endmodule : cfb_device
`default_nettype wire

// ---- rtl/cfb_pkg.sv ----
// package: constants and state types for the clock fan-out configuration link
// Functional notes
// R1 - power-up enables all eighteen outputs
// R2 - tristate low floats all outputs, high follows
// R3 - enabled outputs copy reference clock uninverted
// R4 - disabled output held low, no toggling
// R5 - respond only to address 1101001, write
// R6 - acknowledge address in ninth clock pulse
// R7 - bytes eight bits, MSB first, then acknowledge
// R8 - data changes only while clock low
// R9 - data falling while clock high: start
// R10 - data rising while clock high: stop
// R11 - master frames transfer, sends address first
// R12 - acknowledge data bytes until start or stop
// R13 - command and count bytes acknowledged, ignored
// R14 - bytes load in order, no sub-addressing
// R15 - slave receiver only, no read back
// R16 - first byte bit n enables output n
// R17 - second byte bit n enables output n+8
// R18 - third byte bits 7,6 enable 17,16
// R19 - tristate low overrides enables
package cfb_pkg;
  localparam int          CFB_NUM_OUT     = 18;
  localparam logic [6:0]  CFB_SLAVE_ADDR  = 7'h69;
  localparam logic [17:0] CFB_EN_RESET    = 18'h3FFFF;
  localparam int          CFB_LOW_POS     = 0;
  localparam int          CFB_MID_POS     = 8;
  localparam int          CFB_HIGH_POS    = 16;
  localparam int          CFB_HIGH_BITPOS = 6;
  localparam int          CFB_BYTE_CMD    = 0;
  localparam int          CFB_BYTE_CNT    = 1;
  localparam int          CFB_BYTE_LOW    = 2;
  localparam int          CFB_BYTE_MID    = 3;
  localparam int          CFB_BYTE_HIGH   = 4;
  localparam int          CFB_CLK_DIV     = 40;
  typedef enum logic [2:0] {CFB_D_IDLE, CFB_D_RECV, CFB_D_ACK, CFB_D_ACKEND, CFB_D_IGNORE} cfb_dev_st_t;
  typedef enum logic [3:0] {CFB_H_IDLE, CFB_H_START, CFB_H_BIT_LO, CFB_H_BIT_HI, CFB_H_ACK_LO, CFB_H_ACK_HI,
                            CFB_H_STOP_LO, CFB_H_STOP_HI, CFB_H_DONE} cfb_host_st_t;
endpackage : cfb_pkg

// ---- rtl/cfb_link_if.sv ----
// interface: two-wire link between configuration master and fan-out device
`timescale 1ns/1ps
`default_nettype none
interface cfb_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // open drain with pull-up: any enabled low driver wins
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
  modport slave (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : cfb_link_if
`default_nettype wire

// ---- rtl/cfb_host.sv ----
// module: two-wire master that writes the three enable bytes
`timescale 1ns/1ps
`default_nettype none
module cfb_host
  import cfb_pkg::*;
#(
  parameter int CLK_DIV = CFB_CLK_DIV
)(
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  cfb_link_if.master       link,
  input  wire logic [2:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [7:0]       rdata_o
);
  // regs: 0..2 enable bytes, 3 go (write) / status (read: bit0 busy, bit1 nack seen)
  localparam logic [2:0] REG_GO = 3'h3;
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0][7:0] bytes;
    cfb_host_st_t    st;
    logic [15:0]     div;
    logic [2:0]      bitc;
    logic [2:0]      idx;
    logic [7:0]      sh;
    logic            nack;
    logic            scl;
    logic            sda;
    logic [7:0]      rdata;
  } cfb_host_t;

  cfb_host_t s_r;
  cfb_host_t s_nxt;
  logic      tick;

  // frame order: address, command, count, then the three enable bytes; no sub-addressing
  function automatic logic [7:0] frame_byte(input logic [2:0] i, input logic [2:0][7:0] b);
    case (i)
      3'h0: frame_byte = {CFB_SLAVE_ADDR, 1'b0}; // R11
      3'h3: frame_byte = b[0]; // R14
      3'h4: frame_byte = b[1]; // R14
      3'h5: frame_byte = b[2]; // R14
      default: frame_byte = 8'h00; // R13
    endcase
  endfunction : frame_byte

  always_comb begin
    s_nxt = s_r;
    tick  = (s_r.div == 16'(CLK_DIV / 2 - 1));
    s_nxt.div = tick ? 16'h0000 : s_r.div + 16'h0001;
    s_nxt.rdata = 8'h00;
    if (rd_i) begin
      if (addr_i < REG_GO) s_nxt.rdata = s_r.bytes[addr_i[1:0]];
      else if (addr_i == REG_GO) s_nxt.rdata = {6'h00, s_r.nack, s_r.st != CFB_H_IDLE};
    end
    if (wr_i && addr_i < REG_GO) s_nxt.bytes[addr_i[1:0]] = wdata_i;
    if (wr_i && addr_i == REG_GO && s_r.st == CFB_H_IDLE) begin
      s_nxt.st   = CFB_H_START;
      s_nxt.nack = 1'b0;
      s_nxt.idx  = 3'h0;
      s_nxt.div  = 16'h0000;
    end else if (tick) begin
      case (s_r.st)
        CFB_H_START: begin
          s_nxt.sda  = 1'b0; // R11 R9
          s_nxt.sh   = frame_byte(s_r.idx, s_r.bytes);
          s_nxt.bitc = 3'h7;
          s_nxt.st   = CFB_H_BIT_LO;
        end
        // data moves one phase after the clock falls and one before it rises, never beside an edge
        CFB_H_BIT_LO: begin
          if (s_r.scl) begin
            s_nxt.scl = 1'b0;
          end else begin
            s_nxt.sda = s_r.sh[7]; // R8 R7
            s_nxt.st  = CFB_H_BIT_HI;
          end
        end
        CFB_H_BIT_HI: begin
          if (!s_r.scl) begin
            s_nxt.scl = 1'b1;
          end else begin
            s_nxt.sh   = {s_r.sh[6:0], 1'b0};
            s_nxt.bitc = s_r.bitc - 3'h1;
            s_nxt.st   = (s_r.bitc == 3'h0) ? CFB_H_ACK_LO : CFB_H_BIT_LO;
          end
        end
        CFB_H_ACK_LO: begin
          if (s_r.scl) begin
            s_nxt.scl = 1'b0;
          end else begin
            s_nxt.sda = 1'b1; // R8
            s_nxt.st  = CFB_H_ACK_HI;
          end
        end
        CFB_H_ACK_HI: begin
          if (!s_r.scl) begin
            s_nxt.scl = 1'b1;
          end else begin
            if (link.sda) s_nxt.nack = 1'b1; // R7
            s_nxt.idx  = s_r.idx + 3'h1;
            s_nxt.sh   = frame_byte(s_r.idx + 3'h1, s_r.bytes);
            s_nxt.bitc = 3'h7;
            s_nxt.st   = (link.sda || s_r.idx == 3'h5) ? CFB_H_STOP_LO : CFB_H_BIT_LO;
          end
        end
        CFB_H_STOP_LO: begin
          if (s_r.scl) begin
            s_nxt.scl = 1'b0;
          end else begin
            s_nxt.sda = 1'b0; // R8
            s_nxt.st  = CFB_H_STOP_HI;
          end
        end
        CFB_H_STOP_HI: begin
          if (!s_r.scl) begin
            s_nxt.scl = 1'b1;
          end else begin
            s_nxt.sda = 1'b1; // R10 R11
            s_nxt.st  = CFB_H_IDLE;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_r     <= '0;
      s_r.st  <= CFB_H_IDLE;
      s_r.scl <= 1'b1;
      s_r.sda <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.scl_o    = 1'b0;
  assign link.scl_oe   = ~s_r.scl;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = ~s_r.sda;
  assign rdata_o       = s_r.rdata;
endmodule : cfb_host
`default_nettype wire

// ---- verification/cfb_link_props.sv ----
// checker: wire-level properties of the configuration slave
`timescale 1ns/1ps
`default_nettype none
module cfb_link_props #(
  parameter int CLK_DIV = 40
)(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_oe
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic       first_r;
  logic       match_r;
  logic [1:0] rise_r;
  logic [9:0] hold_r;
  logic       start;
  logic       rise;
  assign start = scl & scl_q & sda_q & ~sda;
  assign rise  = scl & ~scl_q;
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      bit_r   <= 4'h0;
      sh_r    <= 8'h00;
      first_r <= 1'b0;
      match_r <= 1'b0;
      rise_r  <= 2'h0;
      hold_r  <= 10'h000;
    end else begin
      scl_q   <= scl;
      sda_q   <= sda;
      bit_r   <= start ? 4'h0 : (rise ? ((bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1) : bit_r);
      first_r <= start | (first_r & ~(rise & (bit_r == 4'h8)));
      match_r <= start ? 1'b0 : ((rise && bit_r == 4'h8 && first_r) ? (sh_r == 8'hD2) : match_r);
      sh_r    <= rise ? {sh_r[6:0], sda} : sh_r;
      rise_r  <= sda_s_oe ? rise_r + {1'b0, rise} : 2'h0;
      hold_r  <= sda_s_oe ? hold_r + 10'h001 : 10'h000;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  ack_edge_a: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave data moved while clock high");
  ack_drive_a: assert property (rise && bit_r == 4'h8 && (first_r ? sh_r == 8'hD2 : match_r) |-> sda_s_oe)
    else $error("byte of a matched frame not acknowledged");
  ack_slot_a: assert property ($rose(sda_s_oe) |-> bit_r == 4'h8)
    else $error("acknowledge not after eighth bit");
  ack_addr_a: assert property ($rose(sda_s_oe) && first_r |-> sh_r == 8'hD2)
    else $error("acknowledge to foreign address");
  ack_pulse_a: assert property ($fell(sda_s_oe) |-> rise_r == 2'h1)
    else $error("acknowledge not one clock pulse");
  ack_short_a: assert property (int'(hold_r) <= 6 * CLK_DIV)
    else $error("slave drove data too long");
  stop_idle_a: assert property (scl && $rose(sda) |-> !sda_s_oe)
    else $error("slave driving at stop");
  ack_hold_a: assert property ($rose(scl) && sda_s_oe |=> sda_s_oe)
    else $error("acknowledge dropped in high phase");
endmodule : cfb_link_props
`default_nettype wire

// ---- verification/tb.sv ----
// testbench: host and device joined over the two-wire link
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cfb_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic [2:0]  addr      = 3'h0;
  logic [7:0]  wdata     = 8'h00;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic [7:0]  rdata;
  logic        rin       = 1'b0;
  logic [3:0]  ph        = 4'h0;
  logic        tsc       = 1'b1;
  logic [17:0] bco;
  logic [17:0] boe;
  logic [17:0] en_st;
  int          n_fail    = 0;
  int          num_checks = 0;
  cfb_link_if lnk();
  cfb_host #(.CLK_DIV(8)) cfb_host_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(lnk),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
  cfb_device cfb_device_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(lnk),
    .reference_clock_in_i(rin), .tristate_control_i(tsc), .buffered_clock_out_o(bco),
    .buffered_clock_oe_o(boe), .enable_state_o(en_st));
  cfb_link_props #(.CLK_DIV(8)) cfb_link_props_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .scl(lnk.scl), .sda(lnk.sda), .sda_s_oe(lnk.sda_s_oe));
  always #12.5 ref_clk_i = ~ref_clk_i;
  // reference toggles every eight cycles: longer than the synchroniser lag, so levels can be compared
  always @(posedge ref_clk_i) begin
    ph  <= ph + 4'h1;
    rin <= ph[3];
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk_i);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk_i);
    rd   <= 1'b0;
    @(negedge ref_clk_i);
    d = rdata;
  endtask : rd_reg
  // no sub-addressing: every frame carries all three bytes in order
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    logic [7:0] st;
    wr_reg(3'h0, b0);
    wr_reg(3'h1, b1);
    wr_reg(3'h2, b2);
    wr_reg(3'h3, 8'h01);
    st = 8'h01;
    for (int i = 0; i < 2000 && st[0] !== 1'b0; i++)
      rd_reg(3'h3, st);
    chk({16'h0, st[1:0]}, 18'h0);
  endtask : frame
  task automatic obs(input logic [17:0] en);
    logic [17:0] o_or;
    logic [17:0] o_and;
    logic [6:0]  hist;
    o_or  = 18'h0;
    o_and = 18'h3FFFF;
    hist  = 7'h55;
    repeat (64) begin
      @(negedge ref_clk_i);
      o_or  = o_or | bco;
      o_and = o_and & bco;
      hist  = {hist[5:0], rin};
      // reference steady for seven cycles: outputs show its level, never its inverse
      if (hist == 7'h7F) chk(bco, en);
      if (hist == 7'h00) chk(bco, 18'h0);
    end
    chk(o_or, en);
    chk(o_and, 18'h0);
    chk(boe, 18'h3FFFF);
  endtask : obs
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] d;
    chk(en_st, 18'h3FFFF);
    obs(18'h3FFFF);
    rd_reg(3'h5, d);
    chk({10'h0, d}, 18'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_cfg;
    // reserved low bits of the third byte are set to prove they are ignored
    frame(8'h5A, 8'hC3, 8'hAA);
    chk(en_st, {2'b10, 8'hC3, 8'h5A});
    obs({2'b10, 8'hC3, 8'h5A});
    frame(8'hA5, 8'h3C, 8'h7F);
    chk(en_st, {2'b01, 8'h3C, 8'hA5});
    obs({2'b01, 8'h3C, 8'hA5});
    $display("config test done");
  endtask : t_cfg
  task automatic t_tri;
    logic [17:0] o_or;
    logic [17:0] o_oe;
    o_or = 18'h0;
    o_oe = 18'h0;
    @(posedge ref_clk_i);
    tsc <= 1'b0;
    repeat (8) @(negedge ref_clk_i);
    // enables stay set meanwhile, so any leak past the override would show
    repeat (32) begin
      @(negedge ref_clk_i);
      o_or = o_or | bco;
      o_oe = o_oe | boe;
    end
    chk(o_oe, 18'h0);
    chk(o_or, 18'h0);
    @(posedge ref_clk_i);
    tsc <= 1'b1;
    repeat (8) @(negedge ref_clk_i);
    obs({2'b01, 8'h3C, 8'hA5});
    $display("tristate test done");
  endtask : t_tri
  task automatic t_rst;
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    repeat (3) @(negedge ref_clk_i);
    chk(en_st, 18'h3FFFF);
    @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    obs(18'h3FFFF);
    $display("second reset test done");
  endtask : t_rst
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    t_reset();
    t_cfg();
    t_tri();
    t_rst();
    test_done();
  end
  initial begin
    #1000000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
endmodule : tb
`default_nettype wire
